// file: core/apsc_buf2.sv
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module apsc_buf2 (
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       in_valid,
	input  wire logic [7:0] in_data,
	output logic            in_ready,
	output logic            out_valid,
	output logic [7:0]      out_data,
	input  wire logic       out_ready
);
	import apsc_pkg::*;
	logic [7:0] mem [0:1];
	logic [7:0] next_mem [0:1];
	logic       wr, rd, next_wr, next_rd;
	logic [1:0] cnt, next_cnt;
	logic       next_in_ready, next_out_valid;
	logic [7:0] next_out_data;
	logic       push, pop;

	// pointer and occupancy update; ready drops only when both entries hold words
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_mem[0] = mem[0];
		next_mem[1] = mem[1];
		next_wr = wr;
		next_rd = rd;
		next_cnt = cnt;
		if (push) begin
			next_mem[wr] = in_data;
			next_wr = ~wr;
		end
		if (pop)
			next_rd = ~rd;
		if (push && !pop)
			next_cnt = cnt + 2'd1;
		else if (pop && !push)
			next_cnt = cnt - 2'd1;
		next_in_ready = (next_cnt != APSC_BUF_DEPTH);
		next_out_valid = (next_cnt != 2'd0);
		next_out_data = next_mem[next_rd]; // head entry after this edge, kept in a flop
	end

	// register state
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
			wr <= 1'b0;
			rd <= 1'b0;
			cnt <= 2'd0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= 8'h00;
		end else begin
			mem[0] <= next_mem[0];
			mem[1] <= next_mem[1];
			wr <= next_wr;
			rd <= next_rd;
			cnt <= next_cnt;
			in_ready <= next_in_ready;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
		end
	end

endmodule : apsc_buf2

// file: core/apsc_codec.sv
// packet decoder and encoder of the application service
`timescale 1ns/1ps
// Function
// - check words must xor to fixed constant
// - packet identifier and pad byte sent zero
// - serial command payload goes out serial port, first 1492 bytes only
// - options 0x02 on serial command requests ack
// - ack is command 0x80, no body
// - sample reports sent from port 0xbee
// - sample report command 0x04, set count
// - digital mask at 9 and 10
// - analog mask at offset 11
// - digital word only when mask nonzero
// - analog samples sixteen bits, high first
// - command 0x03 is memory command
// - subcommand 0x06 verifies and installs firmware
// - memory options zero means no ack
module apsc_codec (
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	input  wire logic                   rx_valid,
	input  wire apsc_pkg::apsc_stream_t rx_byte,
	input  wire logic [31:0]            rx_src_addr,
	output logic                        rx_ready,
	output logic                        ser_valid,
	output logic [7:0]                  ser_data,
	input  wire logic                   ser_ready,
	input  wire logic                   sample_req,
	input  wire apsc_pkg::apsc_sample_t sample,
	input  wire logic [31:0]            destination_address_setting,
	output logic                        tx_valid,
	output apsc_pkg::apsc_stream_t      tx_byte,
	input  wire logic                   tx_ready,
	output logic [31:0]                 tx_dest_addr,
	output logic [15:0]                 tx_src_port,
	output logic                        fw_install,
	output apsc_pkg::apsc_install_t     fw_info,
	output logic                        bad_packet
);
	import apsc_pkg::*;

	typedef enum logic [1:0] {RX_HEAD, RX_SERIAL, RX_MEM, RX_DROP} apsc_rx_t;
	typedef enum logic [1:0] {TX_IDLE, TX_HEAD, TX_DIG, TX_ANA} apsc_tx_t;

	apsc_rx_t        rx_state, next_rx_state;
	logic [10:0]     rx_idx, next_rx_idx;
	logic [15:0]     chk1, next_chk1, chk2, next_chk2;
	logic [7:0]      cmd, next_cmd, opt, next_opt, sub, next_sub;
	logic [31:0]     src_addr, next_src_addr, ack_addr, next_ack_addr;
	apsc_install_t   mem_hdr, next_mem_hdr, next_fw_info;
	logic            next_fw_install, next_bad_packet;
	logic            ack_pend, next_ack_pend, samp_pend, next_samp_pend;
	logic            take, push, ack_set;
	logic [10:0]     pay_idx;
	apsc_rx_t        after_head;

	// received bytes enter the serial buffer only while payload is forwarded
	apsc_buf2 u_ser_buf (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_valid  (push),
		.in_data   (rx_byte.data),
		.in_ready  (rx_ready),
		.out_valid (ser_valid),
		.out_data  (ser_data),
		.out_ready (ser_ready)
	);

	// receive parser: header check, command dispatch, payload and memory capture
	always_comb begin
		take = rx_valid && rx_ready;
		pay_idx = rx_idx - APSC_OFS_BODY;
		push = take && (rx_state == RX_SERIAL) && (pay_idx < APSC_SERIAL_MAX);
		next_rx_state = rx_state;
		next_rx_idx = rx_idx;
		next_chk1 = chk1;
		next_chk2 = chk2;
		next_cmd = cmd;
		next_opt = opt;
		next_sub = sub;
		next_src_addr = src_addr;
		next_mem_hdr = mem_hdr;
		next_fw_info = fw_info;
		next_fw_install = 1'b0;
		next_bad_packet = 1'b0;
		ack_set = 1'b0;
		after_head = RX_DROP;
		if (take) begin
			if (rx_idx != APSC_IDX_MAX)
				next_rx_idx = rx_idx + 11'd1;
			case (rx_state)
				RX_HEAD: begin
					case (rx_idx)
						APSC_OFS_CHK1_HI: begin
							next_chk1[15:8] = rx_byte.data;
							next_src_addr = rx_src_addr;
						end
						APSC_OFS_CHK1_LO: next_chk1[7:0] = rx_byte.data;
						APSC_OFS_CHK2_HI: next_chk2[15:8] = rx_byte.data;
						APSC_OFS_CHK2_LO: begin
							next_chk2[7:0] = rx_byte.data;
						end
						APSC_OFS_CMD: next_cmd = rx_byte.data;
						APSC_OFS_OPT: begin
							next_opt = rx_byte.data;
							if ((chk1 ^ chk2) != APSC_CHECK_XOR) begin
								next_bad_packet = 1'b1;
							end else if (cmd == APSC_CMD_SERIAL)
								after_head = RX_SERIAL;
							else if (cmd == APSC_CMD_MEMORY)
								after_head = RX_MEM;
							next_rx_state = after_head;
							if (after_head == RX_SERIAL && rx_byte.data == APSC_OPT_ACK_REQ)
								ack_set = rx_byte.last;
						end
						default: ; // id and pad bytes carry nothing on receive
					endcase
				end
				RX_SERIAL: ack_set = rx_byte.last && (opt == APSC_OPT_ACK_REQ);
				RX_MEM: begin
					case (rx_idx)
						APSC_OFS_BODY:     next_sub = rx_byte.data;
						APSC_OFS_MEM_OPT:  next_mem_hdr.memory_subcommand_options = rx_byte.data;
						APSC_OFS_BLK_HI:   next_mem_hdr.memory_block_number[15:8] = rx_byte.data;
						APSC_OFS_BLK_LO:   next_mem_hdr.memory_block_number[7:0] = rx_byte.data;
						APSC_OFS_START_HI: next_mem_hdr.memory_start_index[15:8] = rx_byte.data;
						APSC_OFS_START_LO: next_mem_hdr.memory_start_index[7:0] = rx_byte.data;
						APSC_OFS_COUNT_HI: next_mem_hdr.memory_byte_count[15:8] = rx_byte.data;
						APSC_OFS_COUNT_LO: next_mem_hdr.memory_byte_count[7:0] = rx_byte.data;
						default: ; // memory payload unused by install
					endcase
					// fields are high byte first; install fires on the packet's last byte if its header is complete by then
					if (rx_byte.last && rx_idx >= APSC_OFS_COUNT_LO && next_sub == APSC_MEM_INSTALL) begin
						next_fw_install = 1'b1;
						next_fw_info = next_mem_hdr;
					end
					// memory commands never raise an acknowledgment here
					ack_set = 1'b0;
				end
				default: ; // discarded packet
			endcase
			if (rx_byte.last) begin
				next_rx_state = RX_HEAD;
				next_rx_idx = 11'd0;
			end
		end
	end

	// receive state registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_state <= RX_HEAD;
			rx_idx <= 11'd0;
			chk1 <= 16'h0000;
			chk2 <= 16'h0000;
			cmd <= 8'h00;
			opt <= 8'h00;
			sub <= 8'h00;
			src_addr <= 32'h0000_0000;
			mem_hdr <= '0;
			fw_info <= '0;
			fw_install <= 1'b0;
			bad_packet <= 1'b0;
		end else begin
			rx_state <= next_rx_state;
			rx_idx <= next_rx_idx;
			chk1 <= next_chk1;
			chk2 <= next_chk2;
			cmd <= next_cmd;
			opt <= next_opt;
			sub <= next_sub;
			src_addr <= next_src_addr;
			mem_hdr <= next_mem_hdr;
			fw_info <= next_fw_info;
			fw_install <= next_fw_install;
			bad_packet <= next_bad_packet;
		end
	end

	apsc_tx_t     tx_state, next_tx_state;
	logic         kind, next_kind; // 1 for a sample report, 0 for an ack
	logic [3:0]   hidx, next_hidx;
	logic         phase, next_phase;
	logic [2:0]   ch, next_ch;
	apsc_sample_t samp, next_samp, held, next_held;
	logic         slot, next_tx_valid, more_ana;
	apsc_stream_t next_tx_byte;
	logic [31:0]  next_tx_dest_addr;
	logic [7:0]   hbyte, ahigh;

	// pending ack and sample requests; a new request wins over the clearing load
	always_comb begin
		slot = !tx_valid || tx_ready;
		next_ack_pend = ack_pend;
		next_ack_addr = ack_addr;
		next_samp_pend = samp_pend;
		next_held = held;
		if (slot && tx_state == TX_IDLE) begin
			if (ack_pend)
				next_ack_pend = 1'b0;
			else
				next_samp_pend = 1'b0;
		end
		if (ack_set) begin
			next_ack_pend = 1'b1;
			next_ack_addr = src_addr;
		end
		if (sample_req) begin
			next_samp_pend = 1'b1;
			next_held = sample;
		end
	end

	// header byte for the packet being sent
	always_comb begin
		case (hidx)
			4'd0: hbyte = APSC_CHECK_FIRST[15:8];
			4'd1: hbyte = APSC_CHECK_FIRST[7:0];
			4'd2: hbyte = APSC_CHECK_SECOND[15:8];
			4'd3: hbyte = APSC_CHECK_SECOND[7:0];
			4'd4: hbyte = APSC_PACKET_ID;
			4'd5: hbyte = APSC_PAD_BYTE;
			4'd6: hbyte = kind ? APSC_CMD_SAMPLE : APSC_CMD_ACK;
			4'd7: hbyte = APSC_OPT_NONE;
			4'd8: hbyte = APSC_SAMPLE_SETS;
			4'd9: hbyte = samp.dmask[15:8];
			4'd10: hbyte = samp.dmask[7:0];
			4'd11: hbyte = samp.amask;
			default: hbyte = 8'h00;
		endcase
		ahigh = samp.amask >> ch;
		more_ana = (ahigh[7:1] != 7'h00);
	end

	// transmit sequencer: at most one byte per free output slot
	always_comb begin
		next_tx_state = tx_state;
		next_kind = kind;
		next_hidx = hidx;
		next_phase = phase;
		next_ch = ch;
		next_samp = samp;
		next_tx_dest_addr = tx_dest_addr;
		next_tx_valid = tx_valid && !tx_ready;
		next_tx_byte = tx_byte;
		if (slot) begin
			case (tx_state)
				TX_IDLE: begin
					next_hidx = 4'd0;
					if (ack_pend) begin
						next_kind = 1'b0;
						next_tx_dest_addr = ack_addr;
						next_tx_state = TX_HEAD;
					end else if (samp_pend) begin
						next_kind = 1'b1;
						next_samp = held;
						next_tx_dest_addr = destination_address_setting;
						next_tx_state = TX_HEAD;
					end
				end
				TX_HEAD: begin
					next_tx_valid = 1'b1;
					next_tx_byte.data = hbyte;
					next_tx_byte.last = 1'b0;
					next_hidx = hidx + 4'd1;
					next_phase = 1'b0;
					next_ch = 3'd0;
					if (!kind && hidx == APSC_OFS_OPT[3:0]) begin
						next_tx_byte.last = 1'b1;
						next_tx_state = TX_IDLE;
					end else if (kind && hidx == APSC_OFS_AMASK[3:0]) begin
						if (samp.dmask != 16'h0000)
							next_tx_state = TX_DIG;
						else if (samp.amask != 8'h00)
							next_tx_state = TX_ANA;
						else begin
							next_tx_byte.last = 1'b1;
							next_tx_state = TX_IDLE;
						end
					end
				end
				TX_DIG: begin
					next_tx_valid = 1'b1;
					next_tx_byte.data = phase ? samp.dword[7:0] : samp.dword[15:8];
					next_tx_byte.last = phase && (samp.amask == 8'h00);
					next_phase = ~phase;
					if (phase)
						next_tx_state = (samp.amask == 8'h00) ? TX_IDLE : TX_ANA;
				end
				TX_ANA: begin
					if (samp.amask[ch]) begin
						next_tx_valid = 1'b1;
						next_tx_byte.data = phase ? samp.aword[ch][7:0] : samp.aword[ch][15:8];
						next_tx_byte.last = phase && !more_ana;
						next_phase = ~phase;
						if (phase) begin
							next_ch = ch + 3'd1;
							if (!more_ana)
								next_tx_state = TX_IDLE;
						end
					end else
						next_ch = ch + 3'd1; // skip disabled channel
				end
				default: next_tx_state = TX_IDLE;
			endcase
		end
	end

	// transmit state registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_pend <= 1'b0;
			ack_addr <= 32'h0000_0000;
			samp_pend <= 1'b0;
			held <= '0;
			tx_state <= TX_IDLE;
			kind <= 1'b0;
			hidx <= 4'd0;
			phase <= 1'b0;
			ch <= 3'd0;
			samp <= '0;
			tx_valid <= 1'b0;
			tx_byte <= '0;
			tx_dest_addr <= 32'h0000_0000;
			tx_src_port <= APSC_SRC_PORT;
		end else begin
			ack_pend <= next_ack_pend;
			ack_addr <= next_ack_addr;
			samp_pend <= next_samp_pend;
			held <= next_held;
			tx_state <= next_tx_state;
			kind <= next_kind;
			hidx <= next_hidx;
			phase <= next_phase;
			ch <= next_ch;
			samp <= next_samp;
			tx_valid <= next_tx_valid;
			tx_byte <= next_tx_byte;
			tx_dest_addr <= next_tx_dest_addr;
			tx_src_port <= APSC_SRC_PORT;
		end
	end

	// position of the presented byte within the outgoing packet, for checking
	logic [10:0] beat;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			beat <= 11'd0;
		else if (tx_valid && tx_ready)
			beat <= tx_byte.last ? 11'd0 : beat + 11'd1;
	end

	AST_CHECK_HEAD: assert property (@(posedge mclk) disable iff (!arst_n)
		(tx_valid && beat == 11'd0) |-> tx_byte.data == 8'h42)
		else $error("first check byte wrong");
	AST_PAD_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
		(tx_valid && (beat == 11'd4 || beat == 11'd5)) |-> tx_byte.data == 8'h00)
		else $error("packet id or pad byte not zero");
	AST_ACK_LEN: assert property (@(posedge mclk) disable iff (!arst_n)
		(tx_valid && !kind && tx_byte.last) |-> (beat == 11'd7 && tx_byte.data == 8'h00))
		else $error("ack not eight bytes");
	AST_ACK_CMD: assert property (@(posedge mclk) disable iff (!arst_n)
		(tx_valid && !kind && beat == 11'd6) |-> tx_byte.data == 8'h80)
		else $error("ack command byte wrong");
	AST_SAMPLE_CMD: assert property (@(posedge mclk) disable iff (!arst_n)
		(tx_valid && kind && beat == 11'd6) |-> tx_byte.data == 8'h04)
		else $error("sample command byte wrong");
	AST_SRC_PORT: assert property (@(posedge mclk) disable iff (!arst_n)
		tx_valid |-> tx_src_port == 16'h0bee)
		else $error("source port wrong");
	AST_SERIAL_PUSH: assert property (@(posedge mclk) disable iff (!arst_n)
		(take && rx_state == RX_SERIAL && rx_idx < 11'd1500) |-> push)
		else $error("serial payload byte lost");
	AST_DROP_QUIET: assert property (@(posedge mclk) disable iff (!arst_n)
		(take && rx_state == RX_HEAD && rx_idx == 11'd7 && (chk1 ^ chk2) != 16'h4242)
		|=> (bad_packet && !fw_install && rx_state != RX_SERIAL && rx_state != RX_MEM) ##1 !push)
		else $error("bad packet not discarded");
	AST_ACK_REQ: assert property (@(posedge mclk) disable iff (!arst_n)
		(take && rx_byte.last && rx_state == RX_SERIAL && opt == 8'h02) |=> ack_pend)
		else $error("requested ack not queued");
	AST_FW_PULSE: assert property (@(posedge mclk) disable iff (!arst_n)
		fw_install |-> ($past(sub) == 8'h06 || sub == 8'h06) ##1 !fw_install)
		else $error("install pulse malformed");
endmodule : apsc_codec

// file: core/apsc_pkg.sv
// shared constants and carrier types of the application-service packet codec
package apsc_pkg;
	// header layout and fixed values
	localparam logic [15:0] APSC_CHECK_XOR     = 16'h4242;
	localparam logic [15:0] APSC_CHECK_FIRST   = 16'h4242;
	localparam logic [15:0] APSC_CHECK_SECOND  = 16'h0000;
	localparam logic [7:0]  APSC_PACKET_ID     = 8'h00;
	localparam logic [7:0]  APSC_PAD_BYTE      = 8'h00;
	localparam logic [7:0]  APSC_CMD_SERIAL    = 8'h00;
	localparam logic [7:0]  APSC_CMD_MEMORY    = 8'h03;
	localparam logic [7:0]  APSC_CMD_SAMPLE    = 8'h04;
	localparam logic [7:0]  APSC_CMD_ACK       = 8'h80;
	localparam logic [7:0]  APSC_OPT_NONE      = 8'h00;
	localparam logic [7:0]  APSC_OPT_ACK_REQ   = 8'h02;
	localparam logic [7:0]  APSC_MEM_INSTALL   = 8'h06;
	localparam logic [7:0]  APSC_SAMPLE_SETS   = 8'h01;
	localparam logic [15:0] APSC_SRC_PORT      = 16'h0bee;
	localparam logic [15:0] APSC_HALF_SCALE    = 16'h0200;
	// byte offsets within a packet, index width and limits, buffer depth
	localparam int          APSC_IDX_W         = 11;
	localparam logic [10:0] APSC_OFS_CHK1_HI   = 11'h000;
	localparam logic [10:0] APSC_OFS_CHK1_LO   = 11'h001;
	localparam logic [10:0] APSC_OFS_CHK2_HI   = 11'h002;
	localparam logic [10:0] APSC_OFS_CHK2_LO   = 11'h003;
	localparam logic [10:0] APSC_OFS_PKT_ID    = 11'h004;
	localparam logic [10:0] APSC_OFS_PAD       = 11'h005;
	localparam logic [10:0] APSC_OFS_CMD       = 11'h006;
	localparam logic [10:0] APSC_OFS_OPT       = 11'h007;
	localparam logic [10:0] APSC_OFS_BODY      = 11'h008;
	localparam logic [10:0] APSC_OFS_DMASK_HI  = 11'h009;
	localparam logic [10:0] APSC_OFS_DMASK_LO  = 11'h00a;
	localparam logic [10:0] APSC_OFS_AMASK     = 11'h00b;
	localparam logic [10:0] APSC_OFS_MEM_OPT   = 11'h009;
	localparam logic [10:0] APSC_OFS_BLK_HI    = 11'h00a;
	localparam logic [10:0] APSC_OFS_BLK_LO    = 11'h00b;
	localparam logic [10:0] APSC_OFS_START_HI  = 11'h00c;
	localparam logic [10:0] APSC_OFS_START_LO  = 11'h00d;
	localparam logic [10:0] APSC_OFS_COUNT_HI  = 11'h00e;
	localparam logic [10:0] APSC_OFS_COUNT_LO  = 11'h00f;
	localparam logic [10:0] APSC_IDX_MAX       = 11'h7ff;
	localparam logic [10:0] APSC_SERIAL_MAX    = 11'd1492;
	localparam logic [1:0]  APSC_BUF_DEPTH     = 2'd2;
	// received or sent byte with end-of-packet mark
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} apsc_stream_t;
	// one I/O sample set offered for reporting
	typedef struct packed {
		logic [15:0]      dmask;
		logic [7:0]       amask;
		logic [15:0]      dword;
		logic [7:0][15:0] aword;
	} apsc_sample_t;
	// decoded firmware verify-and-install request
	typedef struct packed {
		logic [7:0]  memory_subcommand_options;
		logic [15:0] memory_block_number;
		logic [15:0] memory_start_index;
		logic [15:0] memory_byte_count;
	} apsc_install_t;
endpackage : apsc_pkg

// file: tb/apsc_client_model.sv
// network client model that takes the codec's reply packets
`timescale 1ns/1ps
module apsc_client_model (
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	input  wire logic                   slow,
	input  wire logic                   tx_valid,
	input  wire apsc_pkg::apsc_stream_t tx_byte,
	output logic                        tx_ready,
	input  wire logic [31:0]            tx_dest_addr
);
	import apsc_pkg::*;
	logic [8:0]  got_q[$];
	logic [31:0] dest;
	logic        phase;
	// keep each byte taken with its end mark; when slow, ready only every other cycle
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= 1'b0;
			tx_ready <= 1'b0;
		end else begin
			if (tx_valid && tx_ready) begin
				got_q.push_back(tx_byte);
				dest <= tx_dest_addr;
			end
			phase <= ~phase;
			tx_ready <= #1 slow ? phase : 1'b1;
		end
	end
endmodule : apsc_client_model

// file: tb/apsc_codec_tb_top.sv
// self-checking bench of the application-service packet codec
`timescale 1ns/1ps
module apsc_codec_tb_top;
	import apsc_pkg::*;
	typedef struct packed {
		logic [15:0] chk1;
		logic [15:0] chk2;
		logic [7:0]  cmd;
		logic [7:0]  opt;
		logic [10:0] len;
		logic [10:0] exp_ser;
		logic        exp_ack;
		logic        exp_bad;
		logic        stall;
	} apsc_row_t;
	apsc_row_t     rows[8];
	logic          mclk = 1'b0;
	logic          arst_n = 1'b0;
	logic          rx_valid = 1'b0;
	apsc_stream_t  rx_byte = '0;
	logic [31:0]   rx_src_addr = '0;
	logic          rx_ready, ser_valid, tx_valid, fw_install, bad_packet, rdy_s;
	logic [7:0]    ser_data, eb;
	logic          ser_ready = 1'b1;
	logic          sample_req = 1'b0;
	apsc_sample_t  sample = '0;
	logic [31:0]   dest_set = 32'h0a00_0001;
	apsc_stream_t  tx_byte;
	logic          tx_ready, stall = 1'b0, stalled_seen = 1'b0;
	logic [31:0]   tx_dest_addr;
	logic [15:0]   tx_src_port;
	apsc_install_t fw_info, fw_seen;
	logic [3:0]    cyc = 4'h0;
	logic [7:0]    pkt[$], ser_q[$], exp_q[$];
	int            bad_count = 0, checked = 0, fw_cnt = 0, bad_cnt = 0, r, b0;

	apsc_codec i_dut (.mclk(mclk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.rx_src_addr(rx_src_addr), .rx_ready(rx_ready), .ser_valid(ser_valid),
		.ser_data(ser_data), .ser_ready(ser_ready), .sample_req(sample_req), .sample(sample),
		.destination_address_setting(dest_set), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_ready(tx_ready), .tx_dest_addr(tx_dest_addr), .tx_src_port(tx_src_port),
		.fw_install(fw_install), .fw_info(fw_info), .bad_packet(bad_packet));
	apsc_client_model i_client (.mclk(mclk), .arst_n(arst_n), .slow(stall),
		.tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
		.tx_dest_addr(tx_dest_addr));

	// clock at 200 MHz
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// serial sink with optional long stall, and pulse monitors
	always @(posedge mclk) begin
		rdy_s <= rx_ready;
		if (ser_valid && ser_ready) ser_q.push_back(ser_data);
		if (fw_install) fw_cnt++;
		if (fw_install) fw_seen = fw_info;
		if (bad_packet) bad_cnt++;
		cyc <= cyc + 4'h1;
		ser_ready <= #1 !stall || (cyc == 4'h0);
	end

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	// offer pkt byte by byte, holding each until taken
	task automatic send_pkt;
		for (int k = 0; k < pkt.size(); k++) begin
			rx_valid = 1'b1;
			rx_byte = {pkt[k], k == pkt.size() - 1};
			do begin
				@(posedge mclk);
				#1;
				if (!rdy_s) stalled_seen = 1'b1;
			end while (!rdy_s);
		end
		rx_valid = 1'b0;
	endtask : send_pkt

	// compare the reply bytes taken by the client with exp_q
	task automatic check_tx(input string what);
		check({what, " length"}, exp_q.size(), i_client.got_q.size());
		for (int k = 0; k < exp_q.size() && k < i_client.got_q.size(); k++)
			check(what, {exp_q[k], k == exp_q.size() - 1}, i_client.got_q[k]);
	endtask : check_tx

	// request one sample report and build its expected bytes
	task automatic do_sample(input logic [15:0] dm, input logic [7:0] am, input logic [15:0] dw);
		@(posedge mclk);
		#1;
		sample.dmask = dm;
		sample.amask = am;
		sample.dword = dw;
		for (int ch = 0; ch < 8; ch++) sample.aword[ch] = {ch[7:0], 8'ha5};
		sample.aword[0] = 16'h0200;
		sample_req = 1'b1;
		i_client.got_q.delete();
		exp_q = '{8'h42, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h01, dm[15:8],
			dm[7:0], am};
		if (dm != 16'h0000) exp_q = {exp_q, dw[15:8], dw[7:0]};
		for (int ch = 0; ch < 8; ch++)
			if (am[ch]) exp_q = {exp_q, sample.aword[ch][15:8], sample.aword[ch][7:0]};
		@(posedge mclk);
		#1;
		sample_req = 1'b0;
		repeat (120) @(posedge mclk);
		#1;
		check_tx("sample bytes");
		check("sample dest", dest_set, i_client.dest);
		check("source port", 16'h0bee, tx_src_port);
	endtask : do_sample

	// outputs while reset is held
	task automatic check_reset;
		check("reset rx_ready", 1'b1, rx_ready);
		check("reset tx_valid", 1'b0, tx_valid);
		check("reset ser_valid", 1'b0, ser_valid);
		check("reset pulses", 2'b00, {fw_install, bad_packet});
		check("reset source port", 16'h0bee, tx_src_port);
	endtask : check_reset

	// send one table row, then compare serial output, discard pulse and reply
	task automatic run_row(input int n);
		stall = rows[n].stall;
		rx_src_addr = 32'hc0a8_0010 + n;
		ser_q.delete();
		i_client.got_q.delete();
		b0 = bad_cnt;
		pkt = '{rows[n].chk1[15:8], rows[n].chk1[7:0], rows[n].chk2[15:8], rows[n].chk2[7:0],
			8'h00, 8'h00, rows[n].cmd, rows[n].opt};
		for (int j = 0; j < rows[n].len; j++) pkt.push_back(8'h30 + j[7:0]);
		send_pkt();
		repeat (60 + (rows[n].stall ? 17 * rows[n].len : 0)) @(posedge mclk);
		#1;
		check("serial count", rows[n].exp_ser, ser_q.size());
		for (int j = 0; j < ser_q.size(); j++) begin
			eb = 8'h30 + j[7:0];
			check("serial byte", eb, ser_q[j]);
		end
		check("bad pulse", rows[n].exp_bad, bad_cnt - b0);
		exp_q.delete();
		if (rows[n].exp_ack) exp_q = '{8'h42, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
		check_tx("ack bytes");
		if (rows[n].exp_ack) check("ack dest", rx_src_addr, i_client.dest);
	endtask : run_row

	// watchdog
	initial begin
		#100us;
		bad_count++;
		close_out();
	end

	initial begin
		rows = '{'{16'h4242, 16'h0000, 8'h00, 8'h02, 11'd5, 11'd5, 1'b1, 1'b0, 1'b0},
			'{16'h4040, 16'h0202, 8'h00, 8'h02, 11'd6, 11'd6, 1'b1, 1'b0, 1'b1},
			'{16'h4242, 16'h0001, 8'h00, 8'h02, 11'd4, 11'd0, 1'b0, 1'b1, 1'b0},
			'{16'h4242, 16'h0000, 8'h01, 8'h02, 11'd4, 11'd0, 1'b0, 1'b0, 1'b0},
			'{16'h4242, 16'h0000, 8'h03, 8'h00, 11'd4, 11'd0, 1'b0, 1'b0, 1'b0},
			'{16'h4242, 16'h0000, 8'h00, 8'h02, 11'd0, 11'd0, 1'b1, 1'b0, 1'b0},
			'{16'h4242, 16'h0000, 8'h00, 8'h00, 11'd1494, 11'd1492, 1'b0, 1'b0, 1'b0},
			'{16'h4242, 16'h0000, 8'h00, 8'h02, 11'd5, 11'd5, 1'b1, 1'b0, 1'b0}};
		repeat (2) @(posedge mclk);
		#1;
		check_reset();
		arst_n = 1'b1;
		for (r = 0; r < 8; r++) run_row(r);
		check("buffer full", 1'b1, stalled_seen);
		check("no install", 0, fw_cnt);
		// firmware verify and install, no ack requested
		stall = 1'b0;
		i_client.got_q.delete();
		pkt = '{8'h42, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06, 8'h07, 8'h00,
			8'h05, 8'h00, 8'h10, 8'h00, 8'h20};
		send_pkt();
		repeat (40) @(posedge mclk);
		#1;
		check("install count", 1, fw_cnt);
		check("install fields", {8'h07, 16'h0005, 16'h0010, 16'h0020}, fw_seen);
		check("install no ack", 0, i_client.got_q.size());
		stall = 1'b1;
		do_sample(16'h8001, 8'h83, 16'h1234);
		stall = 1'b0;
		do_sample(16'h0000, 8'h81, 16'hffff);
		// reset while a report is on its way; none of it may resume afterwards
		sample_req = 1'b1;
		@(posedge mclk);
		#1;
		sample_req = 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		check("report under way", 1'b1, tx_valid);
		arst_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		check_reset();
		arst_n = 1'b1;
		run_row(0);
		close_out();
	end
endmodule : apsc_codec_tb_top
